// [design/seg_disp_pkg.sv]
/*
 * Shared constants and carriers for the segment display control block.
 * Assumes an 8-bit register port with one-cycle strobes on a single clock.
 */
package seg_disp_pkg;

    // ==========================================
    // Register byte addresses
    localparam logic [15:0] DISPLAY_CONTROL_ADDR = 16'h50a0;
    localparam logic [15:0] CONTRAST_ADJUST_ADDR = 16'h50a1;
    localparam logic [15:0] DRIVE_CLOCK_CONTROL_ADDR = 16'h50a2;
    localparam logic [15:0] VOLTAGE_REGULATOR_CONTROL_ADDR = 16'h50a3;
    localparam logic [15:0] VOLTAGE_BOOSTER_CONTROL_ADDR = 16'h50a4;
    localparam logic [15:0] INTERRUPT_MASK_ADDR = 16'h50a5;
    localparam logic [15:0] INTERRUPT_FLAGS_ADDR = 16'h50a6;

    // ==========================================
    // Field positions
    localparam int SEGMENT_ORDER_BIT = 7;
    localparam int COMMON_ORDER_BIT = 6;
    localparam int SCREEN_AREA_BIT = 5;
    localparam int IMAGE_INVERT_N_BIT = 4;
    localparam int DISPLAY_STATE_LSB = 0;
    localparam int CONTRAST_LSB = 0;
    localparam int FRAME_IRQ_BIT = 0;

    // ==========================================
    // Reset values
    localparam logic [7:0] DISPLAY_CONTROL_RESET = 8'hd0;
    localparam logic [3:0] CONTRAST_RESET = 4'h0;
    localparam logic [7:0] DRIVE_CLOCK_RESET = 8'h00;
    localparam logic [7:0] REGULATOR_RESET = 8'h00;
    localparam logic [7:0] BOOSTER_RESET = 8'h00;

    // ==========================================
    // Interrupt vector identity
    localparam logic [7:0] FRAME_IRQ_VECTOR = 8'h0a;
    localparam logic [7:0] FRAME_IRQ_VECTOR_OFFSET = 8'h28;

    // ==========================================
    // Display states
    typedef enum logic [1:0] {
        DISPLAY_OFF = 2'h0,
        DISPLAY_NORMAL = 2'h1,
        DISPLAY_ALL_ON = 2'h2,
        DISPLAY_ALL_OFF = 2'h3
    } display_state_t;

    // ==========================================
    // Register port carrier
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Steering toward the drive waveform generator
    typedef struct packed {
        logic segment_ascending;
        logic common_ascending;
        logic screen_area;
        logic invert;
        logic all_on;
        logic all_off_static;
        logic normal_image;
        logic drive_enable;
        logic [3:0] contrast_level;
    } drive_ctl_t;

endpackage

// [design/segment_display_control_irq.sv]
/*
 * Register bank, display state steering and frame interrupt of a
 * segment/common display driver.
 * Assumes a same-clock register master, a one-cycle frame pulse from the
 * waveform timing logic, and a panel driver that obeys the steering word.
 */
// Behaviour
// RULE1 - Area-select bit picks screen area at 1/16
// RULE2 - Segment order: 1 ascending, 0 descending
// RULE3 - Common order: 1 ascending, 0 descending
// RULE4 - State code: off, normal, all-on, all-off
// RULE5 - State code resets to display off
// RULE6 - Display off stops feed, levels grounded
// RULE7 - All-on/all-off change waveform only
// RULE8 - Software keeps off until clock ready
// RULE9 - Sleep keeps state; software turns off
// RULE10 - Contrast field picks one of sixteen
// RULE11 - Contrast resets to lightest level
// RULE12 - Inversion bit zero inverts image
// RULE13 - Inversion ignored in all-off, kept all-on
// RULE14 - Flag set once per frame
// RULE15 - Enable zero blocks the request
// RULE16 - Request when flag and enable set
// RULE17 - Writing one clears the flag
// RULE18 - Software clears flag before enabling
// RULE19 - Frame interrupt uses vector ten
// RULE20 - Eight-bit registers at consecutive bytes
// RULE21 - Software writes zero to reserved bits
// RULE22 - New frame beats a same-cycle clear
`timescale 1ns/1ps

module segment_display_control_irq
    import seg_disp_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Timing logic and mode inputs
    input wire logic frame_pulse_in,
    input wire logic duty_16_in,
    // Drive steering
    output drive_ctl_t drive_ctl_out,
    output logic [4:0] drive_level_ground_out,
    output logic regulator_feed_enable_out,
    // Interrupt controller
    output logic frame_irq_out,
    output logic [7:0] frame_irq_vector_out,
    output logic [7:0] frame_irq_vector_offset_out
);

    // ==========================================
    // State
    typedef struct packed {
        logic segment_order_select;
        logic common_order_select;
        logic screen_area_select;
        logic image_invert_n;
        display_state_t display_state_code;
        logic [3:0] contrast_level;
        logic [7:0] drive_clock_control;
        logic [7:0] voltage_regulator_control;
        logic [7:0] voltage_booster_control;
        logic frame_irq_enable;
        logic frame_irq_flag;
        logic [7:0] rdata;
        drive_ctl_t drive_ctl;
        logic feed_enable;
    } state_t;

    state_t state_reg; // Registered state
    state_t state_next; // Next-state copy
    reg_req_t req; // Bundled request

    // Register read mux shared by the read path
    function automatic logic [7:0] read_value(input state_t s, input logic [15:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            DISPLAY_CONTROL_ADDR: begin
                v[SEGMENT_ORDER_BIT] = s.segment_order_select;
                v[COMMON_ORDER_BIT] = s.common_order_select;
                v[SCREEN_AREA_BIT] = s.screen_area_select;
                v[IMAGE_INVERT_N_BIT] = s.image_invert_n;
                v[DISPLAY_STATE_LSB +: 2] = s.display_state_code; // Reserved bits read 0
            end
            CONTRAST_ADJUST_ADDR: v[CONTRAST_LSB +: 4] = s.contrast_level;
            DRIVE_CLOCK_CONTROL_ADDR: v = s.drive_clock_control;
            VOLTAGE_REGULATOR_CONTROL_ADDR: v = s.voltage_regulator_control;
            VOLTAGE_BOOSTER_CONTROL_ADDR: v = s.voltage_booster_control;
            INTERRUPT_MASK_ADDR: v[FRAME_IRQ_BIT] = s.frame_irq_enable;
            INTERRUPT_FLAGS_ADDR: v[FRAME_IRQ_BIT] = s.frame_irq_flag;
            default: v = 8'h00; // Unmapped reads zero
        endcase
        return v;
    endfunction

    // ==========================================
    // Request bundling
    always_comb begin
        req.addr = reg_addr_in;
        req.wdata = reg_wdata_in;
        req.wr = reg_wr_in;
        req.rd = reg_rd_in;
    end

    // ==========================================
    // Next-state logic
    always_comb begin
        logic clear_hit;
        clear_hit = 1'b0;
        state_next = state_reg;
        // Register writes, eight-bit bytes at consecutive addresses
        if (req.wr) begin
            case (req.addr) // RULE20
                DISPLAY_CONTROL_ADDR: begin
                    state_next.segment_order_select = req.wdata[SEGMENT_ORDER_BIT];
                    state_next.common_order_select = req.wdata[COMMON_ORDER_BIT];
                    state_next.screen_area_select = req.wdata[SCREEN_AREA_BIT];
                    state_next.image_invert_n = req.wdata[IMAGE_INVERT_N_BIT];
                    state_next.display_state_code =
                        display_state_t'(req.wdata[DISPLAY_STATE_LSB +: 2]); // RULE4
                end
                CONTRAST_ADJUST_ADDR: begin
                    state_next.contrast_level = req.wdata[CONTRAST_LSB +: 4]; // RULE10
                end
                DRIVE_CLOCK_CONTROL_ADDR: state_next.drive_clock_control = req.wdata;
                VOLTAGE_REGULATOR_CONTROL_ADDR: begin
                    state_next.voltage_regulator_control = req.wdata;
                end
                VOLTAGE_BOOSTER_CONTROL_ADDR: state_next.voltage_booster_control = req.wdata;
                INTERRUPT_MASK_ADDR: state_next.frame_irq_enable = req.wdata[FRAME_IRQ_BIT];
                INTERRUPT_FLAGS_ADDR: clear_hit = req.wdata[FRAME_IRQ_BIT]; // RULE17
                default: clear_hit = 1'b0; // Unmapped writes ignored
            endcase
        end
        // Frame flag: set wins over a same-cycle clear
        if (frame_pulse_in) begin
            state_next.frame_irq_flag = 1'b1; // RULE14 RULE22
        end else if (clear_hit) begin
            state_next.frame_irq_flag = 1'b0; // RULE17
        end
        // Read data valid the cycle after the strobe only
        state_next.rdata = req.rd ? read_value(state_reg, req.addr) : 8'h00;
        // Drive steering derived from the current fields
        state_next.drive_ctl.segment_ascending = state_reg.segment_order_select; // RULE2
        state_next.drive_ctl.common_ascending = state_reg.common_order_select; // RULE3
        // Area select only meaningful at 1/16 duty
        state_next.drive_ctl.screen_area =
            duty_16_in & state_reg.screen_area_select; // RULE1
        state_next.drive_ctl.normal_image = state_reg.display_state_code == DISPLAY_NORMAL;
        // All-on/all-off act on waveform only; memory untouched
        state_next.drive_ctl.all_on = state_reg.display_state_code == DISPLAY_ALL_ON; // RULE7
        state_next.drive_ctl.all_off_static =
            state_reg.display_state_code == DISPLAY_ALL_OFF; // RULE7
        // Inversion suppressed only in all-off
        state_next.drive_ctl.invert = ~state_reg.image_invert_n &
            (state_reg.display_state_code != DISPLAY_ALL_OFF); // RULE12 RULE13
        state_next.drive_ctl.drive_enable =
            state_reg.display_state_code != DISPLAY_OFF; // RULE4
        state_next.drive_ctl.contrast_level = state_reg.contrast_level; // RULE10
        // Feed stops while off; sleep does not alter the code
        state_next.feed_enable = state_reg.display_state_code != DISPLAY_OFF; // RULE6 RULE9
    end

    // ==========================================
    // State register, synchronous reset
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            state_reg <= '0;
            state_reg.segment_order_select <= DISPLAY_CONTROL_RESET[SEGMENT_ORDER_BIT];
            state_reg.common_order_select <= DISPLAY_CONTROL_RESET[COMMON_ORDER_BIT];
            state_reg.screen_area_select <= DISPLAY_CONTROL_RESET[SCREEN_AREA_BIT];
            state_reg.image_invert_n <= DISPLAY_CONTROL_RESET[IMAGE_INVERT_N_BIT];
            state_reg.display_state_code <= DISPLAY_OFF; // RULE5
            state_reg.contrast_level <= CONTRAST_RESET; // RULE11
            state_reg.drive_clock_control <= DRIVE_CLOCK_RESET;
            state_reg.voltage_regulator_control <= REGULATOR_RESET;
            state_reg.voltage_booster_control <= BOOSTER_RESET;
            state_reg.drive_ctl.segment_ascending <= DISPLAY_CONTROL_RESET[SEGMENT_ORDER_BIT];
            state_reg.drive_ctl.common_ascending <= DISPLAY_CONTROL_RESET[COMMON_ORDER_BIT];
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================
    // Outputs
    assign reg_rdata_out = state_reg.rdata;
    assign drive_ctl_out = state_reg.drive_ctl;
    assign regulator_feed_enable_out = state_reg.feed_enable; // RULE6
    // All five levels grounded while off
    assign drive_level_ground_out = {5{~state_reg.feed_enable}}; // RULE6
    // Request only with flag and enable both set
    assign frame_irq_out = state_reg.frame_irq_flag & state_reg.frame_irq_enable; // RULE15 RULE16
    assign frame_irq_vector_out = FRAME_IRQ_VECTOR; // RULE19
    assign frame_irq_vector_offset_out = FRAME_IRQ_VECTOR_OFFSET; // RULE19

endmodule

// [testbench/seg_disp_props.sv]
/* Concurrent checks on the ports of the segment display control block.
   Assumes binding to that block; single clock, synchronous active-low reset. */
`timescale 1ns/1ps
module seg_disp_props
    import seg_disp_pkg::*;
(
    // Clock, reset and register port
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Frame, mode, drive and interrupt
    input wire logic frame_pulse_in,
    input wire logic duty_16_in,
    input wire drive_ctl_t drive_ctl_out,
    input wire logic [4:0] drive_level_ground_out,
    input wire logic regulator_feed_enable_out,
    input wire logic frame_irq_out,
    input wire logic [7:0] frame_irq_vector_out,
    input wire logic [7:0] frame_irq_vector_offset_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    // ==========================================
    // Mirror of the enable bit; the mask is not visible at the ports
    logic en_reg;
    logic clr;
    assign clr = reg_wr_in && reg_addr_in == INTERRUPT_FLAGS_ADDR && reg_wdata_in[0];
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            en_reg <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == INTERRUPT_MASK_ADDR) begin
            en_reg <= reg_wdata_in[0];
        end
    end
    // ==========================================
    // Assertions
    AST_RDATA_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("Read data not zero outside a read");
    AST_RESERVED_NIBBLE: assert property (reg_rd_in && reg_addr_in == CONTRAST_ADJUST_ADDR
        |=> reg_rdata_out[7:4] == 4'h0) else $error("Reserved contrast bits not zero");
    AST_GROUND_OFF: assert property (drive_level_ground_out == {5{!regulator_feed_enable_out}})
        else $error("Drive levels not grounded exactly while off");
    AST_FEED_DRIVE: assert property (regulator_feed_enable_out == drive_ctl_out.drive_enable)
        else $error("Feed and drive enable disagree");
    AST_MASKED: assert property (!en_reg && !$past(en_reg) |-> !frame_irq_out)
        else $error("Interrupt raised while masked");
    AST_FRAME_IRQ: assert property (frame_pulse_in && en_reg && !clr ##1 en_reg && !clr
        |=> frame_irq_out) else $error("Frame did not raise the interrupt");
    AST_W1C: assert property (clr && !frame_pulse_in ##1 !frame_pulse_in |=> !frame_irq_out)
        else $error("Write one did not clear the flag");
    AST_SET_WINS: assert property (clr && frame_pulse_in && en_reg ##1 en_reg && !clr
        |=> frame_irq_out) else $error("Clear beat a same-cycle frame");
    AST_VECTOR: assert property (frame_irq_vector_out == 8'h0a
        && frame_irq_vector_offset_out == 8'h28) else $error("Wrong vector");
    AST_AREA_DUTY: assert property (!$past(duty_16_in) |-> !drive_ctl_out.screen_area)
        else $error("Area select outside sixteen duty");
    AST_ALLOFF_NOINV: assert property (drive_ctl_out.all_off_static |-> !drive_ctl_out.invert)
        else $error("Inversion active in all-off");
    // Main scenarios reached
    COV_IRQ: cover property (frame_pulse_in && en_reg);
    COV_SET_WINS: cover property (clr && frame_pulse_in);
    COV_FEED: cover property ($rose(regulator_feed_enable_out));
endmodule

// [testbench/seg_panel_model.sv]
/* Panel side: frame timing while driven, plus frames on demand.
   Assumes the steering word of the display control block. */
`timescale 1ns/1ps
module seg_panel_model
    import seg_disp_pkg::*;
#(
    parameter int FRAME_LEN = 8
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Bench request and steering
    input wire logic kick_in,
    input wire drive_ctl_t drive_ctl_in,
    // Frame timing
    output logic frame_pulse_out
);
    logic [7:0] phase_reg; // Position within a frame
    // Frames run only while the panel is driven
    always_ff @(posedge clock_in) begin
        if (!rst_b_in || !drive_ctl_in.drive_enable || phase_reg == 8'(FRAME_LEN - 1)) begin
            phase_reg <= 8'h00;
        end else begin
            phase_reg <= phase_reg + 8'h01;
        end
    end
    // One pulse a frame, or on demand
    assign frame_pulse_out = kick_in || (drive_ctl_in.drive_enable && phase_reg == 8'(FRAME_LEN - 1));
endmodule

// [testbench/segment_display_control_irq_bench.sv]
/* Bench for the segment display control block.
   Assumes the package, the block, the panel model and the checker. */
`timescale 1ns/1ps
module segment_display_control_irq_bench
    import seg_disp_pkg::*;
;
    logic clock_in, feed, irq, pulse;
    logic rst_b_in = 0, reg_wr_in = 0, reg_rd_in = 0, kick = 0, duty_16_in = 1;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, rst_exp [7];
    logic [39:0] rows [10];
    drive_ctl_t dc;
    logic [4:0] gnd;
    int num_errors = 0, checks = 0, cycles = 0;
    segment_display_control_irq uut (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .frame_pulse_in(pulse),
        .duty_16_in(duty_16_in), .drive_ctl_out(dc), .drive_level_ground_out(gnd),
        .regulator_feed_enable_out(feed), .frame_irq_out(irq), .frame_irq_vector_out(),
        .frame_irq_vector_offset_out());
    seg_panel_model #(.FRAME_LEN(8)) panel (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .kick_in(kick), .drive_ctl_in(dc), .frame_pulse_out(pulse));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // Hang guard, far above the under two hundred cycles needed
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One strobe cycle; an optional frame in the same cycle
    task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w, input logic k);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= w;
        reg_rd_in <= !w;
        kick <= k;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        kick <= 1'b0;
        #1;
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        // Address, write, read-back, {0,feed,all_on,all_off,invert,seg,com,area}
        rows = '{40'h50a0_0101_48, 40'h50a0_f2f2_67, 40'h50a0_0202_68, 40'h50a0_0303_50,
            40'h50a0_d0d0_06, 40'h50a1_0f0f_06, 40'h50a2_5a5a_06, 40'h50a3_a5a5_06,
            40'h50a4_3c3c_06, 40'h50a7_ff00_06};
        rst_exp = '{8'hd0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        repeat (4) @(posedge clock_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            bus(DISPLAY_CONTROL_ADDR + 16'(i), 8'h00, 1'b0, 1'b0);
            chk(reg_rdata_out, rst_exp[i]);
        end
        chk({dc.segment_ascending, dc.common_ascending, dc.invert, gnd}, 8'hdf);
        $display("Reset test done");
        // Clock already running, so the state code may now leave off
        foreach (rows[i]) begin
            bus(rows[i][39:24], rows[i][23:16], 1'b1, 1'b0);
            bus(rows[i][39:24], 8'h00, 1'b0, 1'b0);
            chk(reg_rdata_out, rows[i][15:8]);
            chk({1'b0, feed, dc.all_on, dc.all_off_static, dc.invert, dc.segment_ascending,
                dc.common_ascending, dc.screen_area}, rows[i][7:0]);
            chk({3'h0, gnd}, {3'h0, {5{!rows[i][6]}}});
        end
        for (int l = 0; l < 16; l++) begin
            bus(CONTRAST_ADJUST_ADDR, 8'(l), 1'b1, 1'b0);
            bus(CONTRAST_ADJUST_ADDR, 8'h00, 1'b0, 1'b0);
            chk({4'h0, dc.contrast_level}, 8'(l));
        end
        duty_16_in <= 1'b0;
        bus(DISPLAY_CONTROL_ADDR, 8'hf0, 1'b1, 1'b0);
        bus(DISPLAY_CONTROL_ADDR, 8'h00, 1'b0, 1'b0);
        chk({7'h0, dc.screen_area}, 8'h00);
        duty_16_in <= 1'b1;
        $display("Register test done");
        // Stale flag cleared before unmasking
        bus(INTERRUPT_FLAGS_ADDR, 8'h01, 1'b1, 1'b0);
        bus(INTERRUPT_FLAGS_ADDR, 8'h00, 1'b0, 1'b1);
        bus(INTERRUPT_FLAGS_ADDR, 8'h00, 1'b0, 1'b0);
        chk(reg_rdata_out, 8'h01);
        chk({7'h0, irq}, 8'h00);
        bus(INTERRUPT_FLAGS_ADDR, 8'h01, 1'b1, 1'b0);
        bus(INTERRUPT_FLAGS_ADDR, 8'h00, 1'b0, 1'b0);
        chk(reg_rdata_out, 8'h00);
        bus(INTERRUPT_MASK_ADDR, 8'h01, 1'b1, 1'b1);
        bus(INTERRUPT_FLAGS_ADDR, 8'h00, 1'b0, 1'b0);
        chk({7'h0, irq}, 8'h01);
        // Frame and clear in one cycle: the flag must survive
        bus(INTERRUPT_FLAGS_ADDR, 8'h01, 1'b1, 1'b1);
        bus(INTERRUPT_FLAGS_ADDR, 8'h00, 1'b0, 1'b0);
        chk({reg_rdata_out[6:0], irq}, 8'h03);
        bus(INTERRUPT_FLAGS_ADDR, 8'h01, 1'b1, 1'b0);
        bus(DISPLAY_CONTROL_ADDR, 8'hd1, 1'b1, 1'b0);
        repeat (12) @(posedge clock_in);
        bus(INTERRUPT_FLAGS_ADDR, 8'h00, 1'b0, 1'b0);
        chk(reg_rdata_out, 8'h01);
        // Display off before any sleep
        bus(DISPLAY_CONTROL_ADDR, 8'hd0, 1'b1, 1'b0);
        $display("Interrupt test done");
        results();
    end
endmodule
bind segment_display_control_irq seg_disp_props chk_i (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .frame_pulse_in(frame_pulse_in), .duty_16_in(duty_16_in), .drive_ctl_out(drive_ctl_out),
    .drive_level_ground_out(drive_level_ground_out), .frame_irq_out(frame_irq_out),
    .regulator_feed_enable_out(regulator_feed_enable_out),
    .frame_irq_vector_out(frame_irq_vector_out),
    .frame_irq_vector_offset_out(frame_irq_vector_offset_out));
